// >>> rtl/bpw_bridge_pwm.sv
// Bridge PWM enable qualification, two-phase oscillator with sync, and dead-time sequencing.
// Assumes comparator inputs arrive as clean levels synchronous to clk; registers on a plain strobe port.
//
// The register offsets and the address-and-strobe port were left to the implementer.
`include "bpw_defs.svh"
`timescale 1ns/1ns
`default_nettype none

module bpw_bridge_pwm
	import bpw_pkg::*;
(
	input  wire logic        clk,
	input  wire logic        sys_rst,
	input  wire logic        clk_en,
	input  wire logic [4:0]  reg_addr,
	input  wire logic [31:0] reg_wdata,
	input  wire logic        reg_wr,
	input  wire logic        reg_rd,
	output logic      [31:0] reg_rdata,
	input  wire logic        supply_above_rising,
	input  wire logic        supply_above_falling,
	input  wire logic        reference_good,
	input  wire logic        thermal_ok,
	input  wire logic        overvoltage_overtemp_input,
	input  wire logic        enable_in,
	input  wire logic        soft_start_at_pulse_level,
	input  wire logic        frequency_set_sync_input,
	input  wire logic        peak_current_trip,
	output logic             primary_drive_a,
	output logic             primary_drive_b,
	output logic             rectifier_drive_a,
	output logic             rectifier_drive_b,
	output logic             soft_start_charge_on
);
	logic [1:0]  ctrl;
	logic [11:0] osc_period;
	logic [7:0]  primary_off_to_rect_on_gap;
	logic [7:0]  rect_off_to_primary_on_gap;
	logic [11:0] on_limit;
	logic        supply_lockout;
	logic        qual_ok;
	logic [9:0]  en_cnt;
	logic        enable_ok;
	bpw_state_t  state;
	bpw_state_t  next_state;
	logic [11:0] osc_cnt;
	logic        phase;
	logic        sync_q;
	logic        sync_locked;
	bpw_seq_t    seq;
	bpw_seq_t    next_seq;
	logic [11:0] on_cnt;
	logic        gap_start;
	logic [7:0]  gap_len;
	wire  logic  gap_done;

	// Register decode
	wire logic sel_ctrl   = (reg_addr == `BPW_ADDR_CTRL);
	wire logic sel_period = (reg_addr == `BPW_ADDR_OSC_PERIOD);
	wire logic sel_gaps   = (reg_addr == `BPW_ADDR_GAPS);
	wire logic sel_limit  = (reg_addr == `BPW_ADDR_ON_LIMIT);
	wire logic sel_status = (reg_addr == `BPW_ADDR_STATUS);
	wire logic sync_mode  = ctrl[`BPW_CTRL_SYNC_BIT];
	wire logic cur_mode   = ctrl[`BPW_CTRL_CMODE_BIT];

	// Status word shows the block's own state
	wire logic [31:0] status_word = {23'h000000, sync_locked, seq, phase, enable_ok,
		qual_ok, supply_lockout, state};
	wire logic [31:0] read_mux =
		sel_ctrl   ? {30'h00000000, ctrl} :
		sel_period ? {20'h00000, osc_period} :
		sel_gaps   ? {16'h0000, rect_off_to_primary_on_gap, primary_off_to_rect_on_gap} :
		sel_limit  ? {20'h00000, on_limit} :
		sel_status ? status_word : 32'h00000000;

	// Register writes and registered read data, zero outside a read answer
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			ctrl                       <= `BPW_RST_CTRL;
			osc_period                 <= `BPW_RST_OSC_PERIOD;
			primary_off_to_rect_on_gap <= 8'(`BPW_GAP_NOM_CYC);
			rect_off_to_primary_on_gap <= 8'(`BPW_GAP_NOM_CYC);
			on_limit                   <= `BPW_RST_ON_LIMIT;
			reg_rdata                  <= 32'h00000000;
		end else if (clk_en) begin
			if (reg_wr && sel_ctrl)
				ctrl <= reg_wdata[1:0];
			if (reg_wr && sel_period)
				osc_period <= reg_wdata[11:0];
			if (reg_wr && sel_gaps) begin
				primary_off_to_rect_on_gap <= reg_wdata[`BPW_GAPS_PS_LSB +: 8];
				rect_off_to_primary_on_gap <= reg_wdata[`BPW_GAPS_SP_LSB +: 8];
			end
			if (reg_wr && sel_limit)
				on_limit <= reg_wdata[11:0];
			reg_rdata <= reg_rd ? read_mux : 32'h00000000;
		end
	end

	// Lockout with hysteresis: set above rising threshold, cleared below falling one
	always_ff @(posedge clk) begin
		if (sys_rst)
			supply_lockout <= 1'b0;
		else if (clk_en) begin
			if (supply_above_rising)
				supply_lockout <= 1'b1;
			else if (!supply_above_falling)
				supply_lockout <= 1'b0;
		end
	end

	// All start-up qualifiers at once
	assign qual_ok = supply_lockout && reference_good && thermal_ok
		&& !overvoltage_overtemp_input;

	// Enable is accepted high only after the minimum width; it drops at once
	wire logic en_full   = (en_cnt == 10'(`BPW_EN_MIN_CYC - 1));
	wire logic valid_rise = enable_in && !enable_ok && en_full;
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			en_cnt    <= 10'h000;
			enable_ok <= 1'b0;
		end else if (clk_en) begin
			en_cnt    <= (!enable_in || enable_ok) ? 10'h000 : en_cnt + 10'h001;
			enable_ok <= enable_in && (enable_ok || en_full);
		end
	end

	// Enable state machine
	always_comb begin
		next_state = state;
		case (state)
			ST_OFF: begin
				if (qual_ok && valid_rise)
					next_state = ST_START;
			end
			ST_START: begin
				if (!enable_in)
					next_state = soft_start_at_pulse_level ? ST_OFF : ST_PULSE;
				else if (soft_start_at_pulse_level)
					next_state = ST_LEVEL;
			end
			ST_LEVEL: begin
				if (!enable_in)
					next_state = ST_OFF;
			end
			ST_PULSE: begin
				if (valid_rise)
					next_state = ST_OFF;
			end
			default: next_state = ST_OFF;
		endcase
		if (!qual_ok)
			next_state = ST_OFF;
	end

	wire logic next_run = (next_state != ST_OFF);

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			state                <= ST_OFF;
			soft_start_charge_on <= 1'b0;
		end else if (clk_en) begin
			state                <= next_state;
			soft_start_charge_on <= next_run;
		end
	end

	// Oscillator: internal period clamped to the sync range, or restarted by falling sync edges
	wire logic [11:0] lim_cyc  = 12'(`BPW_SYNC_LIM_CYC);
	wire logic [11:0] fast_cyc = 12'(`BPW_SYNC_FAST_CYC);
	wire logic [11:0] eff_period = (osc_period > lim_cyc) ? lim_cyc :
		(osc_period < fast_cyc) ? fast_cyc : osc_period;
	wire logic sync_fall  = sync_q && !frequency_set_sync_input;
	wire logic fast_ok    = (osc_cnt >= fast_cyc - 12'h001);
	wire logic sync_hit   = sync_fall && fast_ok;
	wire logic clamp_hit  = (osc_cnt >= lim_cyc - 12'h001);
	wire logic cyc_end    = sync_mode ? (sync_hit || clamp_hit)
		: (osc_cnt >= eff_period - 12'h001); // A shortened period never lets the count run past it
	wire logic next_phase = next_run ? (phase ^ cyc_end) : 1'b0;

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			osc_cnt     <= 12'h000;
			phase       <= 1'b0;
			sync_q      <= 1'b0;
			sync_locked <= 1'b0;
		end else if (clk_en) begin
			osc_cnt     <= (cyc_end || !next_run) ? 12'h000 : osc_cnt + 12'h001;
			phase       <= next_phase;
			sync_q      <= frequency_set_sync_input;
			sync_locked <= sync_mode && (cyc_end ? sync_hit : sync_locked);
		end
	end

	// Primary ends at peak current in current mode, or at the on-time limit
	wire logic pri_end = (seq == SEQ_PRI) && ((cur_mode && peak_current_trip)
		|| (on_cnt >= on_limit));

	// Drive sequence: gap, primary, gap, rectifier
	always_comb begin
		next_seq  = seq;
		gap_start = 1'b0;
		gap_len   = rect_off_to_primary_on_gap;
		if (!next_run || cyc_end) begin
			next_seq  = SEQ_SP;
			gap_start = 1'b1;
		end else begin
			case (seq)
				SEQ_SP: begin
					if (gap_done)
						next_seq = SEQ_PRI;
				end
				SEQ_PRI: begin
					if (pri_end) begin
						next_seq  = SEQ_PS;
						gap_start = 1'b1;
						gap_len   = primary_off_to_rect_on_gap;
					end
				end
				SEQ_PS: begin
					if (gap_done)
						next_seq = SEQ_REST;
				end
				SEQ_REST: next_seq = SEQ_REST;
				default: next_seq = SEQ_SP;
			endcase
		end
	end

	bpw_gap_timer u_gap (
		.clk     (clk),
		.sys_rst (sys_rst),
		.clk_en  (clk_en),
		.start   (gap_start),
		.length  (gap_len),
		.done    (gap_done)
	);

	// Sequence state and on-time count
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			seq    <= SEQ_SP;
			on_cnt <= 12'h000;
		end else if (clk_en) begin
			seq    <= next_seq;
			on_cnt <= (next_seq == SEQ_PRI && seq == SEQ_PRI) ? on_cnt + 12'h001 : 12'h000;
		end
	end

	// Outputs from flip-flops; a rectifier runs in the other phase's tail and drops
	// as its own cycle starts, so its fall precedes its primary rise by the gap
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			primary_drive_a   <= 1'b0;
			primary_drive_b   <= 1'b0;
			rectifier_drive_a <= 1'b0;
			rectifier_drive_b <= 1'b0;
		end else if (clk_en) begin
			primary_drive_a   <= next_run && (next_seq == SEQ_PRI) && !next_phase;
			primary_drive_b   <= next_run && (next_seq == SEQ_PRI) && next_phase;
			rectifier_drive_a <= next_run && (next_seq == SEQ_REST) && next_phase;
			rectifier_drive_b <= next_run && (next_seq == SEQ_REST) && !next_phase;
		end
	end

	// Checks
	sequence s_start_entered;
		state == ST_OFF && clk_en ##1 state == ST_START;
	endsequence

	sequence s_early_fall;
		clk_en && state == ST_START && !enable_in && !soft_start_at_pulse_level && qual_ok;
	endsequence

	sequence s_late_level;
		clk_en && state == ST_START && enable_in && soft_start_at_pulse_level && qual_ok;
	endsequence

	chk_start_qualified: assert property (@(posedge clk) disable iff (sys_rst)
		s_start_entered |-> $past(qual_ok) && $past(enable_in))
		else $error("start without qualifiers");

	chk_soft_start_on: assert property (@(posedge clk) disable iff (sys_rst)
		(state != ST_OFF) |-> soft_start_charge_on)
		else $error("soft-start source off while enabled");

	chk_level_drop: assert property (@(posedge clk) disable iff (sys_rst)
		clk_en && state == ST_LEVEL && !enable_in |=> state == ST_OFF)
		else $error("level enable drop did not disable");

	chk_pulse_mode: assert property (@(posedge clk) disable iff (sys_rst)
		s_early_fall |=> state == ST_PULSE)
		else $error("early enable fall not taken as pulse");

	chk_level_mode: assert property (@(posedge clk) disable iff (sys_rst)
		s_late_level |=> state == ST_LEVEL)
		else $error("enable after threshold not taken as level");

	chk_min_width: assert property (@(posedge clk) disable iff (sys_rst)
		clk_en && !enable_ok && !en_full |=> !enable_ok)
		else $error("short enable pulse accepted");

	chk_sync_clamp: assert property (@(posedge clk) disable iff (sys_rst)
		sync_mode |-> osc_cnt < lim_cyc)
		else $error("oscillator below lower sync limit");

	chk_sync_edge: assert property (@(posedge clk) disable iff (sys_rst)
		clk_en && sync_mode && sync_hit && next_run |=> osc_cnt == 12'h000 && seq == SEQ_SP)
		else $error("cycle not started at sync falling edge");

	chk_pri_gap: assert property (@(posedge clk) disable iff (sys_rst)
		$rose(primary_drive_a) || $rose(primary_drive_b)
		|-> !rectifier_drive_a && !rectifier_drive_b)
		else $error("primary rose with rectifier on");

	chk_lockout_standby: assert property (@(posedge clk) disable iff (sys_rst)
		clk_en && !supply_above_rising && !supply_above_falling |=> ##1 state == ST_OFF)
		else $error("not in stand-by below lockout");

	chk_pri_exclusive: assert property (@(posedge clk) disable iff (sys_rst)
		!(primary_drive_a && primary_drive_b) && !(rectifier_drive_a && rectifier_drive_b))
		else $error("both phases active together");

	chk_off_when_down: assert property (@(posedge clk) disable iff (sys_rst)
		clk_en && !qual_ok |=> !primary_drive_a && !primary_drive_b
		&& !rectifier_drive_a && !rectifier_drive_b)
		else $error("outputs active while disabled");
endmodule
`default_nettype wire

// >>> rtl/bpw_defs.svh
// Constants of the bridge PWM enable and timing block: offsets, fields, reset values, timing counts.
// Assumes a 250 MHz core clock; included by bare name from the bridge PWM module.
`ifndef BPW_DEFS_SVH
`define BPW_DEFS_SVH

// Register byte offsets
`define BPW_ADDR_CTRL        5'h00
`define BPW_ADDR_OSC_PERIOD  5'h04
`define BPW_ADDR_GAPS        5'h08
`define BPW_ADDR_ON_LIMIT    5'h0c
`define BPW_ADDR_STATUS      5'h10

// Control and gap register fields
`define BPW_CTRL_SYNC_BIT    0
`define BPW_CTRL_CMODE_BIT   1
`define BPW_GAPS_PS_LSB      0
`define BPW_GAPS_SP_LSB      8

// Clock and times in their printed units
`define BPW_CLK_MHZ          250
`define BPW_EN_MIN_US        3
`define BPW_SYNC_MIN_KHZ     170
`define BPW_SYNC_MAX_KHZ     2300
`define BPW_GAP_NOM_NS       40

// Derived cycle counts
`define BPW_EN_MIN_CYC       (`BPW_EN_MIN_US * `BPW_CLK_MHZ)
`define BPW_SYNC_LIM_CYC     ((`BPW_CLK_MHZ * 1000) / `BPW_SYNC_MIN_KHZ)
`define BPW_SYNC_FAST_CYC    ((`BPW_CLK_MHZ * 1000 + `BPW_SYNC_MAX_KHZ - 1) / `BPW_SYNC_MAX_KHZ)
`define BPW_GAP_NOM_CYC      ((`BPW_GAP_NOM_NS * `BPW_CLK_MHZ + 999) / 1000)

// Reset values
`define BPW_RST_CTRL         2'h0
`define BPW_RST_OSC_PERIOD   12'h271
`define BPW_RST_ON_LIMIT     12'h12c

`endif

// >>> rtl/bpw_gap_timer.sv
// Dead-time counter used for both gaps of the drive sequence.
// Assumes the caller ignores done while it reloads; start has priority over counting.
`timescale 1ns/1ns
`default_nettype none
module bpw_gap_timer
	import bpw_pkg::*;
(
	input  wire logic       clk,
	input  wire logic       sys_rst,
	input  wire logic       clk_en,
	input  wire logic       start,
	input  wire logic [7:0] length,
	output wire logic       done
);
	logic [7:0] cnt;
	logic       busy;

	// Done one cycle after start for a zero gap, else after length cycles more
	assign done = busy && (cnt == 8'h00);

	// Load on start, count down while busy
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			cnt  <= 8'h00;
			busy <= 1'b0;
		end else if (clk_en) begin
			if (start) begin
				cnt  <= length;
				busy <= 1'b1;
			end else if (done) begin
				busy <= 1'b0;
			end else if (busy) begin
				cnt <= cnt - 8'h01;
			end
		end
	end
endmodule
`default_nettype wire

// >>> rtl/bpw_pkg.sv
// Types shared by the bridge PWM enable and timing block.
// Assumes nothing beyond the constants header.
`default_nettype none
package bpw_pkg;

	// Enable state, Gray along off, start, level
	typedef enum logic [1:0] {
		ST_OFF   = 2'b00,
		ST_START = 2'b01,
		ST_LEVEL = 2'b11,
		ST_PULSE = 2'b10
	} bpw_state_t;

	// Per-cycle drive sequence, Gray along the cycle
	typedef enum logic [1:0] {
		SEQ_SP   = 2'b00,
		SEQ_PRI  = 2'b01,
		SEQ_PS   = 2'b11,
		SEQ_REST = 2'b10
	} bpw_seq_t;

endpackage
`default_nettype wire

// >>> sim/bpw_gate_driver_model.sv
// Gate driver model on the far side of the bridge PWM block: measures drive edges.
// Assumes registered drive outputs sampled on the rising edge of clk.
`timescale 1ns/1ns
`default_nettype none
module bpw_gate_driver_model (
	input  wire logic clk,
	input  wire logic pa,
	input  wire logic pb,
	input  wire logic ra,
	input  wire logic rb,
	output int        per,
	output int        wid,
	output int        ps_gap,
	output int        sp_gap,
	output logic      overlap
);
	int   cnt = 0;
	int   t_pr = 0;
	int   t_pf = 0;
	int   t_rf = 0;
	logic pa_q = 1'b0;
	logic ra_q = 1'b0;
	logic rb_q = 1'b0;
	logic ovl_seen = 1'b0;

	// Sticky shoot-through flag, clear from time zero
	assign overlap = ovl_seen;

	// Edge timing of the primary and rectifier drives
	always @(posedge clk) begin
		cnt <= cnt + 1;
		pa_q <= pa;
		ra_q <= ra;
		rb_q <= rb;
		if (pa && !pa_q) begin
			per <= cnt - t_pr;
			t_pr <= cnt;
			sp_gap <= cnt - t_rf;
		end
		if (!pa && pa_q) begin
			wid <= cnt - t_pr;
			t_pf <= cnt;
		end
		if (!ra && ra_q)
			t_rf <= cnt;
		if (rb && !rb_q)
			ps_gap <= cnt - t_pf;
		if ((pa && pb) || (ra && rb))
			ovl_seen <= 1'b1; // Shoot-through would damage the bridge
	end
endmodule
`default_nettype wire

// >>> sim/tb_top.sv
// Testbench of the bridge PWM block: register tasks and enable, drive and sync tests.
// Assumes the design sources and the gate driver model are compiled first.
`timescale 1ns/1ns
`default_nettype none
module tb_top;
	logic        clk = 0;
	logic        sys_rst = 1;
	logic        ce = 1'b1;
	logic [4:0]  addr = 0;
	logic [31:0] wd = 0;
	logic        wr_s = 0;
	logic        rd_s = 0;
	logic [31:0] rdata;
	logic [3:0]  q = 4'hf;
	logic        sf = 1;
	logic        en = 0;
	logic        ss = 0;
	logic        sync = 1;
	logic        sync_run = 0;
	logic        trip = 0;
	logic        pa, pb, ra, rb, ss_on;
	logic        ovl;
	int          per, wid, ps_gap, sp_gap;
	int          sc = 0;
	int          cyc = 0;
	int          miscompares = 0;
	int          tests_run = 0;

	always #2 clk = ~clk;

	bpw_bridge_pwm i_dut (.clk(clk), .sys_rst(sys_rst), .clk_en(ce), .reg_addr(addr),
		.reg_wdata(wd), .reg_wr(wr_s), .reg_rd(rd_s), .reg_rdata(rdata),
		.supply_above_rising(q[0]), .supply_above_falling(sf), .reference_good(q[1]),
		.thermal_ok(q[2]), .overvoltage_overtemp_input(~q[3]), .enable_in(en),
		.soft_start_at_pulse_level(ss), .frequency_set_sync_input(sync),
		.peak_current_trip(trip), .primary_drive_a(pa), .primary_drive_b(pb),
		.rectifier_drive_a(ra), .rectifier_drive_b(rb), .soft_start_charge_on(ss_on));

	bpw_gate_driver_model i_drv (.clk(clk), .pa(pa), .pb(pb), .ra(ra), .rb(rb),
		.per(per), .wid(wid), .ps_gap(ps_gap), .sp_gap(sp_gap), .overlap(ovl));

	// External sync clock, 300 cycles with half duty; idles high when stopped
	always @(posedge clk) begin
		if (sync_run) begin
			sc <= (sc == 299) ? 0 : sc + 1;
			sync <= (sc < 150);
		end else begin
			sc   <= 0;
			sync <= 1'b1;
		end
	end

	// Hang guard
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc == 60000) begin
			miscompares++;
			report_and_stop();
		end
	end

	task automatic report_and_stop();
		$display("compares %0d mismatches %0d", tests_run, miscompares);
		if (miscompares == 0 && tests_run > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		tests_run++;
		if (got !== exp) begin
			miscompares++;
			$display("mismatch at %0t got %h exp %h", $time, got, exp);
		end
	endtask

	task automatic rng(input int v, input int lo, input int hi);
		tests_run++;
		if (v < lo || v > hi) begin
			miscompares++;
			$display("mismatch at %0t got %h exp %h to %h", $time, v, lo, hi);
		end
	endtask

	task automatic wt(input int n);
		repeat (n) @(posedge clk);
	endtask

	task automatic wr(input logic [4:0] a, input logic [31:0] d);
		@(posedge clk);
		addr <= a;
		wd <= d;
		wr_s <= 1'b1;
		@(posedge clk);
		wr_s <= 1'b0;
	endtask

	task automatic rd(input logic [4:0] a, input logic [31:0] m, input logic [31:0] e);
		@(posedge clk);
		addr <= a;
		rd_s <= 1'b1;
		@(posedge clk);
		rd_s <= 1'b0;
		@(negedge clk);
		chk(rdata & m, e);
		@(posedge clk);
	endtask

	// Enable held past the minimum width with the soft-start level reached
	task automatic run_on();
		ss <= 1'b1;
		en <= 1'b1;
		wt(760);
	endtask

	task automatic run_off();
		en <= 1'b0;
		wt(4);
	endtask

	// Outputs are looked at mid-cycle, then the caller is put back on a rising edge
	task automatic drv_off();
		@(negedge clk);
		chk({27'h0, ss_on, pa, pb, ra, rb}, 32'h0);
		@(posedge clk);
	endtask

	// Main sequence
	initial begin
		wt(12);
		sys_rst <= 1'b0;
		rd(5'h00, 32'hffffffff, 32'h0);
		rd(5'h04, 32'hfff, 32'h271);
		rd(5'h08, 32'hffff, 32'h0a0a);
		rd(5'h0c, 32'hfff, 32'h12c);
		rd(5'h14, 32'hffffffff, 32'h0);
		wr(5'h10, 32'h3);
		rd(5'h10, 32'h3, 32'h0);
		$display("test 1 done");
		for (int i = 0; i < 4; i++) begin
			q <= 4'hf ^ (4'h1 << i);
			sf <= (i != 0); // Lockout only clears below the falling threshold
			en <= 1'b1;
			wt(780);
			drv_off();
			run_off();
		end
		q <= 4'hf;
		sf <= 1'b1;
		en <= 1'b1;
		wt(700);
		en <= 1'b0;
		wt(100);
		drv_off();
		$display("test 2 done");
		wr(5'h04, 32'hc8);
		wr(5'h0c, 32'h64); // On limit well inside the 200-cycle period
		ss <= 1'b0;
		en <= 1'b1;
		wt(760);
		@(negedge clk);
		chk({31'h0, ss_on}, 32'h1);
		rd(5'h10, 32'h3, 32'h1);
		ss <= 1'b1;
		rd(5'h10, 32'h3, 32'h3);
		wt(1000);
		chk(per, 400);
		rng(ps_gap, 10, 13);
		rng(sp_gap, 10, 13);
		wr(5'h08, 32'h0);
		wt(1000);
		rng(ps_gap, 0, 3);
		rng(sp_gap, 0, 3);
		en <= 1'b0;
		wt(2);
		drv_off();
		$display("test 3 done");
		ss <= 1'b0;
		en <= 1'b1;
		wt(760);
		en <= 1'b0;
		rd(5'h10, 32'h3, 32'h2);
		en <= 1'b1;
		wt(700);
		@(negedge clk);
		chk({31'h0, ss_on}, 32'h1);
		wt(60);
		drv_off();
		run_off();
		$display("test 4 done");
		run_on();
		q <= 4'he;
		sf <= 1'b0;
		wt(3);
		drv_off();
		run_off();
		q <= 4'hf;
		sf <= 1'b1;
		run_on();
		q <= 4'h7;
		wt(3);
		drv_off();
		run_off();
		q <= 4'hf;
		$display("test 5 done");
		wr(5'h0c, 32'h14);
		wr(5'h00, 32'h2);
		trip <= 1'b1;
		run_on();
		wt(1000);
		rng(wid, 1, 3);
		trip <= 1'b0;
		wt(1000);
		chk(wid, 21);
		run_off();
		$display("test 6 done");
		wr(5'h00, 32'h1);
		sync_run <= 1'b1;
		run_on();
		wt(2000);
		chk(per, 600);
		rd(5'h10, 32'h100, 32'h100);
		sync_run <= 1'b0;
		wt(9000);
		rng(per, 2936, 2946);
		// Frozen bus: the read is ignored and the idle read data hold
		ce <= 1'b0;
		rd(5'h00, 32'h3, 32'h0);
		ce <= 1'b1;
		rd(5'h00, 32'h3, 32'h1);
		run_off();
		chk({31'h0, ovl}, 32'h0);
		$display("test 7 done");
		report_and_stop();
	end
endmodule
`default_nettype wire
